// File: shared/can_mode_consts.svh
`ifndef CAN_MODE_CONSTS_SVH
`define CAN_MODE_CONSTS_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define IDX_CTL0 6'h00
`define IDX_CTL1 6'h01
`define IDX_BTR0 6'h02
`define IDX_BTR1 6'h03
`define IDX_RFLG 6'h04
`define IDX_RIER 6'h05
`define IDX_TFLG 6'h06
`define IDX_TIER 6'h07
`define IDX_TARQ 6'h08
`define IDX_TAAK 6'h09
`define IDX_TBSEL 6'h0A
`define IDX_IDAC 6'h0B
`define IDX_RXERR 6'h0E
`define IDX_TXERR 6'h0F
`define IDX_ACC_HI 2'h1

// ****************************************************************
// field positions
// ****************************************************************
`define CTL0_INIT_REQUEST 0
`define CTL0_SLEEP_REQUEST 1
`define CTL0_WAKE_ENABLE 2
`define CTL0_TIME 3
`define CTL0_STOP_IN_WAIT 5
`define CTL0_RXFRM 7
`define RFLG_WAKE_INTERRUPT_FLAG 7
`define CTL1_LOOPB 3
`define CTL1_WMASK 6'h3D

// ****************************************************************
// reset values
// ****************************************************************
`define BYTE_RST 8'h00
`define TFLG_RST 3'h7
`define TX_RECESSIVE 1'b1

// ****************************************************************
// resynchronisation counts
// ****************************************************************
`define SYNC_RECESSIVE_BITS 4'hB
`define SYNC_BUSOFF_RUNS 8'h80

`endif

// File: shared/can_mode_pkg.sv
`default_nettype none
package can_mode_pkg;

   // operating mode of the handshake controller
   typedef enum logic [1:0] {
      ST_RESYNC,
      ST_NORMAL,
      ST_SLEEP,
      ST_INIT
   } mode_state_t;

   // complete state of the main controller
   typedef struct packed {
      mode_state_t st;
      logic rxfrm;
      logic stop_in_wait;
      logic synch;
      logic timer_en;
      logic wake_enable;
      logic sleep_request;
      logic init_request;
      logic [5:0] ctl1;
      logic sleep_acknowledge;
      logic init_acknowledge;
      logic [7:0] btr0;
      logic [7:0] btr1;
      logic [7:0] idac;
      logic [7:0] rier;
      logic wake_interrupt_flag;
      logic [2:0] tflg;
      logic [2:0] tier;
      logic [2:0] tarq;
      logic [2:0] taak;
      logic [2:0] tbsel;
      logic [1:0] phase;
      logic waitreq;
      logic [31:0] rdata;
      logic tx;
      logic abort;
      logic sync_run;
   } ctrl_state_t;

   // recessive-run counter state
   typedef struct packed {
      logic [3:0] bits;
      logic [7:0] runs;
      logic done;
   } sync_state_t;

   // acceptance code and mask storage
   typedef struct packed {
      logic [15:0][7:0] mem;
      logic [7:0] rdata;
   } acc_state_t;

endpackage : can_mode_pkg
`default_nettype wire

// File: shared/mode_link_if.sv
`default_nettype none
interface mode_link_if;
   // acceptance storage port
   logic mem_we;
   logic [3:0] mem_waddr;
   logic [7:0] mem_wdata;
   logic [3:0] mem_raddr;
   logic [7:0] mem_rdata;
   // resynchronisation request and answer
   logic sync_run;
   logic sync_busoff;
   logic sync_done;

   modport ctrl (
      output mem_we, mem_waddr, mem_wdata, mem_raddr,
      input mem_rdata,
      output sync_run, sync_busoff,
      input sync_done
   );
   modport mem (
      input mem_we, mem_waddr, mem_wdata, mem_raddr,
      output mem_rdata
   );
   modport sync (
      input sync_run, sync_busoff,
      output sync_done
   );
endinterface : mode_link_if
`default_nettype wire

// File: core/acc_store.sv
`include "can_mode_consts.svh"
`default_nettype none
module acc_store
   import can_mode_pkg::*;
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   // storage port
   mode_link_if.mem link
);

   acc_state_t q;
   acc_state_t d;

   // one write port, registered read one cycle after the address
   always_comb begin
      d = q;
      if (link.mem_we) begin
         d.mem[link.mem_waddr] = link.mem_wdata;
      end
      d.rdata = q.mem[link.mem_raddr];
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign link.mem_rdata = q.rdata;

endmodule : acc_store
`default_nettype wire

// File: core/bus_resync.sv
`include "can_mode_consts.svh"
`default_nettype none
module bus_resync
   import can_mode_pkg::*;
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   // bit stream from the receive front end
   input wire logic i_bit_tick,
   input wire logic i_rx_bit,
   // request and answer
   mode_link_if.sync link
);

   sync_state_t q;
   sync_state_t d;

   // counts runs of recessive bits; any dominant bit restarts the run
   always_comb begin
      d = q;
      if (!link.sync_run) begin
         d = '0;
      end else if (i_bit_tick && !q.done) begin
         if (!i_rx_bit) begin
            d.bits = 4'h0;
         end else if (q.bits == `SYNC_RECESSIVE_BITS - 4'h1) begin
            d.bits = 4'h0;
            // bus-off waits for many runs, otherwise one is enough
            if (!link.sync_busoff) begin
               d.done = 1'b1; // RL11
            end else if (q.runs == `SYNC_BUSOFF_RUNS - 8'h01) begin
               d.done = 1'b1; // RL12
            end else begin
               d.runs = q.runs + 8'h01; // RL12
            end
         end else begin
            d.bits = q.bits + 4'h1;
         end
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign link.sync_done = q.done;

endmodule : bus_resync
`default_nettype wire

// File: core/can_mode_ctrl.sv
`include "can_mode_consts.svh"
`default_nettype none

// Functional notes
// RL1: sleep entry waits for idle bus
// RL2: sleep acknowledge set on entry
// RL3: sleep request refused while wake flag set
// RL4: sleep ends by software or wake-up
// RL5: sleep request clear ignored before sleep
// RL6: init request aborts traffic, drops sync
// RL7: init acknowledge set on entry
// RL8: init entry resets control and flag registers
// RL9: config registers writable only in init
// RL10: error counters untouched by init
// RL11: resync after 11 recessive bits
// RL12: bus-off waits 128 recessive runs
// RL13: software writes flags after init ends
// RL14: init request clear ignored before init
// RL15: init request forces transmit recessive
// RL16: wait or stop forces transmit recessive (the code forces it in wait only while stop in wait is set)
// RL17: software should sleep before init
// RL18: software enables wake before stop
// RL19: wake disabled ignores bus while asleep
// RL20: control 0 held reset during init
// RL21: acknowledges drop when mode left
// RL22: init wins over sleep, ignores idle
module can_mode_ctrl
   import can_mode_pkg::*;
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   // avalon-mm slave
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // status from the frame engine
   input wire logic i_rx_active,
   input wire logic i_rx_frame_ok,
   input wire logic [2:0] i_tx_done,
   input wire logic [2:0] i_tx_aborted,
   input wire logic [1:0] i_rx_state,
   input wire logic [1:0] i_tx_state,
   input wire logic [7:0] i_rx_err_cnt,
   input wire logic [7:0] i_tx_err_cnt,
   input wire logic i_bus_off,
   input wire logic i_engine_tx,
   // bus line and bit timing
   input wire logic i_rx_bit,
   input wire logic i_bit_tick,
   // cpu power state
   input wire logic i_cpu_wait,
   input wire logic i_cpu_stop,
   // controls and pin
   output logic o_bus_transmit_pin,
   output logic o_engine_abort,
   output logic o_synch,
   output logic o_sleep_acknowledge,
   output logic o_init_acknowledge
);

   // ****************************************************************
   // state and helpers
   // ****************************************************************
   ctrl_state_t q;
   ctrl_state_t d;
   logic [5:0] idx;
   logic [7:0] wd;
   logic req;
   logic wr_en;
   logic init_act;
   logic sleep_act;
   logic init_busy;
   logic is_acc;
   logic force_rec;
   logic [7:0] rbyte;

   mode_link_if link ();

   assign idx = i_avs_address[7:2];
   assign wd = i_avs_writedata[7:0];
   assign req = i_avs_read | i_avs_write;
   // a write lands on the edge that ends the waitrequest-low cycle
   assign wr_en = i_avs_write & (q.phase == 2'h2) & i_avs_byteenable[0];
   assign init_act = q.init_request & q.init_acknowledge;
   assign sleep_act = q.sleep_request & q.sleep_acknowledge;
   // the rxfrm, stop in wait and time bits of control 0 stay locked until both handshake bits are low
   assign init_busy = q.init_request | q.init_acknowledge;
   assign is_acc = (idx[5:4] == `IDX_ACC_HI);

   // ****************************************************************
   // helper blocks
   // ****************************************************************
   // acceptance codes and masks, writable only in init mode
   assign link.mem_we = wr_en & is_acc & init_act; // RL9
   assign link.mem_waddr = idx[3:0];
   assign link.mem_wdata = wd;
   assign link.mem_raddr = idx[3:0];
   assign link.sync_run = q.sync_run;
   assign link.sync_busoff = i_bus_off;

   acc_store u_acc (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .link(link.mem)
   );

   bus_resync u_resync (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_bit_tick(i_bit_tick),
      .i_rx_bit(i_rx_bit),
      .link(link.sync)
   );

   // ****************************************************************
   // register read mux
   // ****************************************************************
   // status fields and error counters come straight from the engine
   always_comb begin
      case (idx)
         `IDX_CTL0: rbyte = {q.rxfrm, i_rx_active, q.stop_in_wait, q.synch,
                             q.timer_en, q.wake_enable, q.sleep_request, q.init_request};
         `IDX_CTL1: rbyte = {q.ctl1, q.sleep_acknowledge, q.init_acknowledge};
         `IDX_BTR0: rbyte = q.btr0;
         `IDX_BTR1: rbyte = q.btr1;
         `IDX_RFLG: rbyte = {q.wake_interrupt_flag, 1'b0, i_rx_state, i_tx_state, 2'b00};
         `IDX_RIER: rbyte = q.rier;
         `IDX_TFLG: rbyte = {5'h00, q.tflg};
         `IDX_TIER: rbyte = {5'h00, q.tier};
         `IDX_TARQ: rbyte = {5'h00, q.tarq};
         `IDX_TAAK: rbyte = {5'h00, q.taak};
         `IDX_TBSEL: rbyte = {5'h00, q.tbsel};
         `IDX_IDAC: rbyte = q.idac;
         `IDX_RXERR: rbyte = i_rx_err_cnt; // RL10
         `IDX_TXERR: rbyte = i_tx_err_cnt; // RL10
         default: rbyte = is_acc ? link.mem_rdata : `BYTE_RST;
      endcase
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      d = q;

      // bus handshake: idle, storage read, answer
      case (q.phase)
         2'h0: begin
            if (req) begin
               d.phase = 2'h1;
            end
         end
         2'h1: begin
            d.phase = 2'h2;
            d.waitreq = 1'b0;
            d.rdata = {24'h00_0000, rbyte};
         end
         2'h2: begin
            d.phase = 2'h0;
            d.waitreq = 1'b1;
         end
         default: begin
            d.phase = 2'h0;
            d.waitreq = 1'b1;
         end
      endcase

      // software writes
      if (wr_en) begin
         case (idx)
            `IDX_CTL0: begin
               // setting is always taken, clearing only in init mode
               if (wd[`CTL0_INIT_REQUEST] || init_act) begin
                  d.init_request = wd[`CTL0_INIT_REQUEST]; // RL14
               end
               if (!init_act) begin
                  // set refused on pending wake, clear needs sleep
                  if (wd[`CTL0_SLEEP_REQUEST] ? !q.wake_interrupt_flag : sleep_act) begin
                     d.sleep_request = wd[`CTL0_SLEEP_REQUEST]; // RL3 RL5
                  end
                  d.wake_enable = wd[`CTL0_WAKE_ENABLE];
               end
               if (!init_busy) begin
                  d.stop_in_wait = wd[`CTL0_STOP_IN_WAIT]; // RL20
                  d.timer_en = wd[`CTL0_TIME];
                  if (wd[`CTL0_RXFRM]) begin
                     d.rxfrm = 1'b0;
                  end
               end
            end
            `IDX_CTL1: begin
               if (init_act) begin
                  d.ctl1 = wd[7:2] & `CTL1_WMASK; // RL9
               end
            end
            `IDX_BTR0: begin
               if (init_act) begin
                  d.btr0 = wd; // RL9
               end
            end
            `IDX_BTR1: begin
               if (init_act) begin
                  d.btr1 = wd; // RL9
               end
            end
            `IDX_IDAC: begin
               if (init_act) begin
                  d.idac = wd; // RL9
               end
            end
            `IDX_RFLG: begin
               if (wd[`RFLG_WAKE_INTERRUPT_FLAG]) begin
                  d.wake_interrupt_flag = 1'b0;
               end
            end
            `IDX_RIER: d.rier = wd;
            `IDX_TFLG: d.tflg = q.tflg & ~wd[2:0];
            `IDX_TIER: d.tier = wd[2:0];
            `IDX_TARQ: d.tarq = wd[2:0];
            `IDX_TBSEL: d.tbsel = wd[2:0];
            default: d.tbsel = d.tbsel;
         endcase
      end

      // engine events after the clears, so a set in the same cycle wins
      if (i_rx_frame_ok) begin
         d.rxfrm = 1'b1;
      end
      d.tflg = d.tflg | i_tx_done;
      d.taak = d.taak | i_tx_aborted;
      d.tarq = d.tarq & ~i_tx_aborted;

      // mode sequencing
      case (q.st)
         ST_NORMAL: begin
            if (q.init_request) begin
               // abort is already driven, so acknowledge at once
               d.st = ST_INIT; // RL22
               d.init_acknowledge = 1'b1; // RL7
               d.synch = 1'b0; // RL6
            end else if (q.sleep_request && !i_rx_active && (&q.tflg)) begin
               d.st = ST_SLEEP; // RL1
               d.sleep_acknowledge = 1'b1; // RL2
            end
         end
         ST_SLEEP: begin
            if (q.init_request) begin
               d.st = ST_INIT; // RL22
               d.sleep_acknowledge = 1'b0; // RL21
               d.init_acknowledge = 1'b1; // RL7
               d.synch = 1'b0; // RL6
            end else if (!q.sleep_request) begin
               d.st = ST_NORMAL; // RL4
               d.sleep_acknowledge = 1'b0; // RL21
            end else if (q.wake_enable && !i_rx_bit) begin
               // dominant level wakes only when enabled
               d.st = ST_NORMAL; // RL19
               d.sleep_request = 1'b0; // RL4
               d.sleep_acknowledge = 1'b0; // RL21
               d.wake_interrupt_flag = 1'b1;
            end
         end
         ST_INIT: begin
            // held in reset; status fields and counters are not stored
            d.rxfrm = 1'b0; // RL8 RL20
            d.stop_in_wait = 1'b0; // RL20
            d.timer_en = 1'b0; // RL20
            d.synch = 1'b0; // RL6
            d.wake_interrupt_flag = 1'b0; // RL8
            d.rier = `BYTE_RST; // RL8
            d.tflg = `TFLG_RST; // RL8
            d.tier = 3'h0; // RL8
            d.tarq = 3'h0; // RL8
            d.taak = 3'h0; // RL8
            d.tbsel = 3'h0; // RL8
            if (!q.init_request) begin
               d.st = ST_RESYNC; // RL11
               d.init_acknowledge = 1'b0; // RL21
               d.sync_run = 1'b1;
            end
         end
         ST_RESYNC: begin
            if (q.init_request) begin
               d.st = ST_INIT;
               d.init_acknowledge = 1'b1; // RL7
               d.sync_run = 1'b0;
            end else if (link.sync_done) begin
               d.st = ST_NORMAL; // RL11 RL12
               d.synch = 1'b1;
               d.sync_run = 1'b0;
            end
         end
         default: begin
            d.st = ST_INIT;
         end
      endcase

      // the new request value acts on the same edge as the write
      d.abort = d.init_request | d.init_acknowledge; // RL6
      // recessive through the whole init handshake, stop, wait with stop in wait set, or loopback
      force_rec = d.abort // RL15
                  | (i_cpu_wait & q.stop_in_wait) | i_cpu_stop // RL16
                  | q.ctl1[`CTL1_LOOPB];
      d.tx = force_rec ? `TX_RECESSIVE : i_engine_tx;
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         q <= '0;
         q.waitreq <= 1'b1;
         q.tflg <= `TFLG_RST;
         q.tx <= `TX_RECESSIVE;
         q.sync_run <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign o_avs_readdata = q.rdata;
   assign o_avs_waitrequest = q.waitreq;
   assign o_bus_transmit_pin = q.tx;
   assign o_engine_abort = q.abort;
   assign o_synch = q.synch;
   assign o_sleep_acknowledge = q.sleep_acknowledge;
   assign o_init_acknowledge = q.init_acknowledge;

endmodule : can_mode_ctrl
`default_nettype wire

// File: tb/can_bus_node.sv
`default_nettype none
module can_bus_node (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   // shared bus line
   input wire logic i_tx_pin,
   input wire logic i_dominant,
   output logic o_rx_bit,
   output logic o_bit_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] div_q;
   // a bit sample every four clocks keeps the long resync waits short
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) div_q <= 2'h0;
      else div_q <= div_q + 2'h1;
   end
   assign o_bit_tick = (div_q == 2'h3);
   // wired-and line: recessive unless some node pulls it dominant
   assign o_rx_bit = i_tx_pin & ~i_dominant;
endmodule : can_bus_node
`default_nettype wire

// File: tb/can_mode_ctrl_assertions.sv
`default_nettype none
module can_mode_ctrl_assertions (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   // register bus
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   // status and controls
   input wire logic i_rx_active,
   input wire logic i_cpu_stop,
   input wire logic o_bus_transmit_pin,
   input wire logic o_engine_abort,
   input wire logic o_synch,
   input wire logic o_sleep_acknowledge,
   input wire logic o_init_acknowledge
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   // ****************
   // mode handshake
   // ****************
   // completed write of control 0 with the init request bit set
   sequence s_init_write;
      i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0] &&
         i_avs_address[7:2] == 6'h00 && i_avs_writedata[0];
   endsequence
   sequence s_abort_quiet;
      o_engine_abort && o_bus_transmit_pin;
   endsequence
   a_init_abort_tx: assert property (s_init_write |=> s_abort_quiet)
      else $error("init write did not abort and silence the pin");
   a_init_ack_timely: assert property (s_init_write ##1 o_engine_abort |-> ##[1:2] o_init_acknowledge)
      else $error("init acknowledge late");
   a_ack_after_abort: assert property ($rose(o_init_acknowledge) |-> $past(o_engine_abort))
      else $error("init acknowledge without abort");
   a_init_tx_quiet: assert property (o_init_acknowledge |-> o_bus_transmit_pin && !o_synch)
      else $error("pin driven or synch kept in init");
   a_abort_drop_ack: assert property ($fell(o_engine_abort) |-> !o_init_acknowledge)
      else $error("init acknowledge kept after leaving init");
   a_sleep_bus_idle: assert property ($rose(o_sleep_acknowledge) |-> !$past(i_rx_active))
      else $error("sleep entered while receiving");
   a_stop_recessive: assert property (i_cpu_stop |=> o_bus_transmit_pin)
      else $error("pin not recessive in stop");
   // ****************
   // register bus
   // ****************
   a_wait_one_cycle: assert property ($fell(o_avs_waitrequest) |=> o_avs_waitrequest)
      else $error("waitrequest low too long");
   a_answer_latency: assert property ($fell(o_avs_waitrequest) |-> $past(i_avs_read, 2) || $past(i_avs_write, 2))
      else $error("answer without request");
   a_read_upper_zero: assert property (!o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h00_0000)
      else $error("upper read data not zero");
endmodule : can_mode_ctrl_assertions
bind can_mode_ctrl can_mode_ctrl_assertions chk_i (.i_core_clk, .i_sys_rst,
   .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_byteenable,
   .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_rx_active,
   .i_cpu_stop, .o_bus_transmit_pin, .o_engine_abort, .o_synch,
   .o_sleep_acknowledge, .o_init_acknowledge);
`default_nettype wire

// File: tb/can_mode_request_handshake_tb_top.sv
`default_nettype none
module can_mode_request_handshake_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_core_clk = 1'b0, i_sys_rst = 1'b1, i_avs_read = 1'b0;
   logic i_avs_write = 1'b0, i_rx_active = 1'b0, i_rx_frame_ok = 1'b0;
   logic i_bus_off = 1'b0, i_engine_tx = 1'b1, i_cpu_wait = 1'b0;
   logic i_cpu_stop = 1'b0, dominant = 1'b0, i_rx_bit, i_bit_tick;
   logic [7:0] i_avs_address = 8'h00, i_rx_err_cnt = 8'h00;
   logic [7:0] i_tx_err_cnt = 8'h00;
   logic [31:0] i_avs_writedata = 32'h0000_0000, o_avs_readdata;
   logic [1:0] i_rx_state = 2'h0, i_tx_state = 2'h0;
   logic [2:0] i_tx_done = 3'h0;
   logic o_avs_waitrequest, o_bus_transmit_pin, o_engine_abort, o_synch;
   logic o_sleep_acknowledge, o_init_acknowledge;
   logic [5:0] cfg [6] = '{6'h01, 6'h02, 6'h03, 6'h0B, 6'h10, 6'h1F};
   int error_cnt = 0, n_tests = 0, cyc = 0, seed = 32'hf611;
   can_mode_ctrl uut (.i_core_clk, .i_sys_rst, .i_avs_address, .i_avs_read,
      .i_avs_write, .i_avs_byteenable(4'h1), .i_avs_writedata,
      .o_avs_readdata, .o_avs_waitrequest, .i_rx_active, .i_rx_frame_ok,
      .i_tx_done, .i_tx_aborted(3'h0), .i_rx_state, .i_tx_state,
      .i_rx_err_cnt, .i_tx_err_cnt, .i_bus_off, .i_engine_tx, .i_rx_bit,
      .i_bit_tick, .i_cpu_wait, .i_cpu_stop, .o_bus_transmit_pin,
      .o_engine_abort, .o_synch, .o_sleep_acknowledge, .o_init_acknowledge);
   can_bus_node node (.i_core_clk, .i_sys_rst, .i_tx_pin(o_bus_transmit_pin),
      .i_dominant(dominant), .o_rx_bit(i_rx_bit), .o_bit_tick(i_bit_tick));
   // 250 MHz core clock
   always #2 i_core_clk = ~i_core_clk;
   // hang guard, well above the longest bus-off resync
   always @(posedge i_core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         complete_run();
      end
   end
   function automatic logic [7:0] exp_rflg(logic wk, logic [7:0] s);
      return {wk, 1'b0, s[1:0], s[3:2], 2'h0};
   endfunction : exp_rflg
   task automatic complete_run();
      if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one bus cycle; waits a clock first so strobes never toggle twice
   task automatic acc(input logic w, input logic [5:0] ix,
      input logic [7:0] wd, output logic [7:0] rd);
      @(posedge i_core_clk);
      i_avs_address <= {ix, 2'h0};
      i_avs_write <= w;
      i_avs_read <= ~w;
      i_avs_writedata <= {24'h00_0000, wd};
      // ends when waitrequest goes low; only the bench timeout ends a stuck wait
      do begin
         @(posedge i_core_clk);
      end while (o_avs_waitrequest !== 1'b0);
      rd = o_avs_readdata[7:0];
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
   endtask : acc
   task automatic wr(input logic [5:0] ix, input logic [7:0] wd);
      logic [7:0] d;
      acc(1'b1, ix, wd, d);
   endtask : wr
   task automatic rdc(input logic [5:0] ix, input logic [7:0] e);
      logic [7:0] d;
      acc(1'b0, ix, 8'h00, d);
      chk(d, e);
   endtask : rdc
   task automatic waitc(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask : waitc
   task automatic ticks(input int n);
      repeat (n) @(posedge i_core_clk iff i_bit_tick);
   endtask : ticks
   // ****************
   // main sequence
   // ****************
   initial begin
      logic [7:0] v, r;
      int k;
      repeat (12) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      rdc(6'h01, 8'h00);
      ticks(14);
      chk(o_synch, 1'b1);
      rdc(6'h0C, 8'h00);
      foreach (cfg[k]) begin
         wr(cfg[k], 8'hFF);
         rdc(cfg[k], 8'h00);
      end
      v = $random(seed);
      i_rx_state <= v[1:0];
      i_tx_state <= v[3:2];
      i_rx_err_cnt <= v;
      i_tx_err_cnt <= ~v;
      wr(6'h05, 8'h80);
      wr(6'h07, 8'h05);
      wr(6'h0A, 8'h02);
      wr(6'h00, 8'h28);
      i_rx_frame_ok <= 1'b1;
      @(posedge i_core_clk);
      i_rx_frame_ok <= 1'b0;
      rdc(6'h00, 8'hB8);
      // init entry resets flags and enables, keeps status and counters
      wr(6'h00, 8'h29);
      waitc(3);
      chk(o_init_acknowledge, 1'b1);
      chk(o_synch, 1'b0);
      chk(o_engine_abort, 1'b1);
      rdc(6'h00, 8'h01);
      rdc(6'h01, 8'h01);
      rdc(6'h05, 8'h00);
      rdc(6'h07, 8'h00);
      rdc(6'h0A, 8'h00);
      rdc(6'h06, 8'h07);
      rdc(6'h04, exp_rflg(1'b0, v));
      rdc(6'h0E, v);
      rdc(6'h0F, ~v);
      wr(6'h00, 8'h29);
      rdc(6'h00, 8'h01);
      foreach (cfg[k]) begin
         r = $random(seed);
         wr(cfg[k], r);
         rdc(cfg[k], (k == 0) ? ((r & 8'hF4) | 8'h01) : r);
      end
      wr(6'h01, 8'h00);
      wr(6'h00, 8'h00);
      ticks(10);
      chk(o_init_acknowledge, 1'b0);
      chk(o_engine_abort, 1'b0);
      chk(o_synch, 1'b0);
      ticks(2);
      waitc(2);
      chk(o_synch, 1'b1);
      rdc(6'h0F, ~v);
      // pin against cpu power states, engine driving dominant
      i_engine_tx <= 1'b0;
      for (k = 0; k < 6; k++) begin
         wr(6'h00, {2'h0, k[0], 5'h00});
         i_cpu_wait <= k[1];
         i_cpu_stop <= k[2];
         waitc(2);
         chk(o_bus_transmit_pin, (k[1] & k[0]) | k[2]);
      end
      i_cpu_stop <= 1'b0;
      i_engine_tx <= 1'b1;
      // sleep waits for idle; early clear and traffic are ignored
      wr(6'h06, 8'h01);
      i_rx_active <= 1'b1;
      wr(6'h00, 8'h02);
      waitc(8);
      chk(o_sleep_acknowledge, 1'b0);
      wr(6'h00, 8'h00);
      i_rx_active <= 1'b0;
      waitc(3);
      chk(o_sleep_acknowledge, 1'b0);
      // buffer 0 empties, now the bus is idle
      i_tx_done <= 3'h1;
      waitc(1);
      i_tx_done <= 3'h0;
      waitc(3);
      chk(o_sleep_acknowledge, 1'b1);
      dominant <= 1'b1;
      waitc(4);
      chk(o_sleep_acknowledge, 1'b1);
      dominant <= 1'b0;
      wr(6'h00, 8'h00);
      waitc(2);
      chk(o_sleep_acknowledge, 1'b0);
      wr(6'h05, 8'h80);
      wr(6'h00, 8'h06);
      waitc(3);
      dominant <= 1'b1;
      waitc(3);
      chk(o_sleep_acknowledge, 1'b0);
      dominant <= 1'b0;
      rdc(6'h04, exp_rflg(1'b1, v));
      ticks(14);
      wr(6'h00, 8'h06);
      acc(1'b0, 6'h00, 8'h00, r);
      chk(r[1], 1'b0);
      wr(6'h04, 8'h80);
      wr(6'h00, 8'h06);
      waitc(3);
      chk(o_sleep_acknowledge, 1'b1);
      wr(6'h00, 8'h00);
      // init wins over a pending sleep on a busy bus
      i_rx_active <= 1'b1;
      wr(6'h00, 8'h03);
      waitc(3);
      chk(o_init_acknowledge, 1'b1);
      chk(o_sleep_acknowledge, 1'b0);
      i_rx_active <= 1'b0;
      wr(6'h00, 8'h02);
      ticks(14);
      waitc(3);
      chk(o_sleep_acknowledge, 1'b1);
      // bus-off exit needs 128 runs of 11 recessive bits
      wr(6'h00, 8'h03);
      waitc(3);
      i_bus_off <= 1'b1;
      wr(6'h00, 8'h00);
      ticks(1400);
      chk(o_synch, 1'b0);
      ticks(12);
      waitc(2);
      chk(o_synch, 1'b1);
      complete_run();
   end
endmodule : can_mode_request_handshake_tb_top
`default_nettype wire
